// ===== dmd_pkg.sv
package dmd_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int DMD_W          = 16;
	localparam int DMD_PW         = 32;
	localparam int DMD_NUM_IDX    = 8;
	localparam int DMD_PTR_W      = 3;
	localparam int DMD_PAGE_W     = 9;
	localparam int DMD_OFS_W      = 7;
	localparam int DMD_IMM13_W    = 13;
	localparam int DMD_IMM8_W     = 8;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int DMD_MODE_BIT   = 7;
	localparam int DMD_OPC_LSB    = 8;
	localparam int DMD_SEL_LSB    = 8;
	localparam int DMD_HALF_LSB   = 16;

	// ==========================================================
	// Whole one-word instructions and opcode patterns
	// ==========================================================
	localparam logic [15:0] WORD_ADD_PRODUCT_TO_ACC  = 16'hce15;
	localparam logic [15:0] WORD_PRODUCT_TO_ACC      = 16'hce14;
	localparam logic [15:0] WORD_SUB_PRODUCT_FROM    = 16'hce16;
	localparam logic [13:0] PAT_SET_PRODUCT_SHIFT    = 14'h3382;
	localparam logic [13:0] PAT_COMPARE_INDEX_REGS   = 14'h3394;
	localparam logic [12:0] PAT_LOAD_INDEX_POINTER   = 13'h0ab1;
	localparam logic [2:0]  PAT_MULTIPLY_IMMEDIATE   = 3'h5;
	localparam logic [4:0]  PAT_LOAD_INDEX_SHORT     = 5'h18;
	localparam logic [4:0]  PAT_LOAD_INDEX_LONG      = 5'h1a;
	localparam logic [4:0]  PAT_LOAD_INDEX_REG       = 5'h06;
	localparam logic [6:0]  PAT_LOAD_PAGE_IMMEDIATE  = 7'h64;
	localparam logic [7:0]  OPC_ADD_INDEX_SHORT      = 8'h7e;
	localparam logic [7:0]  LONG_LOW_BYTE            = 8'h00;

	// Upper-byte opcodes of memory-operand instructions.
	localparam logic [7:0] OPC_LOAD_MULTIPLICAND      = 8'h3c;
	localparam logic [7:0] OPC_LOAD_MULT_ACCUMULATE   = 8'h3d;
	localparam logic [7:0] OPC_LOAD_MULT_MOVE         = 8'h3f;
	localparam logic [7:0] OPC_LOAD_MULT_STORE_PROD   = 8'h3e;
	localparam logic [7:0] OPC_LOAD_MULT_SUBTRACT     = 8'h5b;
	localparam logic [7:0] OPC_MULTIPLY               = 8'h38;
	localparam logic [7:0] OPC_MULTIPLY_ACC_PREV      = 8'h3a;
	localparam logic [7:0] OPC_MULTIPLY_SUB_PREV      = 8'h3b;
	localparam logic [7:0] OPC_MULTIPLY_UNSIGNED      = 8'hcf;
	localparam logic [7:0] OPC_MULT_ACCUMULATE        = 8'h5d;
	localparam logic [7:0] OPC_MULT_ACCUMULATE_MOVE   = 8'h5c;
	localparam logic [7:0] OPC_SQUARE_ACCUMULATE      = 8'h39;
	localparam logic [7:0] OPC_SQUARE_SUBTRACT        = 8'h5a;
	localparam logic [7:0] OPC_LOAD_PRODUCT_HIGH      = 8'h53;
	localparam logic [7:0] OPC_STORE_PRODUCT_HIGH     = 8'h7d;
	localparam logic [7:0] OPC_STORE_PRODUCT_LOW      = 8'h7c;
	localparam logic [7:0] OPC_LOAD_PAGE_POINTER      = 8'h4f;

	// ==========================================================
	// Product shift modes and compare conditions
	// ==========================================================
	localparam logic [1:0] SHIFT_NONE      = 2'h0;
	localparam logic [1:0] SHIFT_LEFT_ONE  = 2'h1;
	localparam logic [1:0] SHIFT_LEFT_FOUR = 2'h2;
	localparam int         SHIFT_BY_ONE    = 1;
	localparam int         SHIFT_BY_FOUR   = 4;
	localparam int         SHIFT_BY_SIX    = 6;
	localparam logic [1:0] CMP_EQUAL       = 2'h0;
	localparam logic [1:0] CMP_LESS        = 2'h1;
	localparam logic [1:0] CMP_GREATER     = 2'h2;
	localparam logic [15:0] MOVE_STEP      = 16'h0001;

	// ==========================================================
	// Sequencer states and pending operations
	// ==========================================================
	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_WORD2 = 3'b001,
		ST_PREAD = 3'b010,
		ST_DREAD = 3'b011,
		ST_WRITE = 3'b100
	} dmd_state_e;

	typedef enum logic [4:0] {
		OP_NONE               = 5'b00000,
		OP_LOAD_MULTIPLICAND  = 5'b00001,
		OP_LOAD_MULT_ACC      = 5'b00010,
		OP_LOAD_MULT_MOVE     = 5'b00011,
		OP_LOAD_MULT_STORE    = 5'b00100,
		OP_LOAD_MULT_SUB      = 5'b00101,
		OP_MULTIPLY           = 5'b00110,
		OP_MULTIPLY_ACC_PREV  = 5'b00111,
		OP_MULTIPLY_SUB_PREV  = 5'b01000,
		OP_MULTIPLY_UNSIGNED  = 5'b01001,
		OP_MULT_ACCUMULATE    = 5'b01010,
		OP_MULT_ACC_MOVE      = 5'b01011,
		OP_SQUARE_ACC         = 5'b01100,
		OP_SQUARE_SUB         = 5'b01101,
		OP_LOAD_PRODUCT_HIGH  = 5'b01110,
		OP_STORE_PRODUCT_HIGH = 5'b01111,
		OP_STORE_PRODUCT_LOW  = 5'b10000,
		OP_LOAD_INDEX_REG     = 5'b10001,
		OP_LOAD_PAGE_POINTER  = 5'b10010,
		OP_LOAD_INDEX_LONG    = 5'b10011
	} dmd_op_e;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        prog;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dmd_mem_req_s;

	typedef struct packed {
		dmd_state_e       st;
		dmd_op_e          op;
		logic [15:0]      addr;
		logic [15:0]      pword;
		logic [2:0]       sel;
		logic             ready;
		dmd_mem_req_s     mem;
		logic [31:0]      acc;
		logic [31:0]      product;
		logic [15:0]      mcand;
		logic [7:0][15:0] index_reg;
		logic [2:0]       index_ptr;
		logic [8:0]       page_ptr;
		logic [1:0]       shift_field;
		logic             test_flag;
	} dmd_core_s;

endpackage

// ===== dmd_mult.sv
`timescale 1ns/100ps

module dmd_mult #(
	parameter int W = 16
) (
	input  wire logic [W-1:0]   a,
	input  wire logic [W-1:0]   b,
	input  wire logic           is_unsigned,
	output logic      [2*W-1:0] p
);

	logic signed [2*W:0] prod_x;

	// Both operands get one extra bit so the same signed multiplier serves the unsigned case.
	always_comb begin
		prod_x = $signed({is_unsigned ? 1'b0 : a[W-1], a}) *
		         $signed({is_unsigned ? 1'b0 : b[W-1], b});
		p = prod_x[2*W-1:0];
	end

endmodule

// ===== dmd_pshift.sv
`timescale 1ns/100ps

module dmd_pshift
	import dmd_pkg::*;
#(
	parameter int PW = 32
) (
	input  wire logic [PW-1:0] p_in,
	input  wire logic [1:0]    mode,
	output logic      [PW-1:0] p_out
);

	always_comb begin
		if (mode == SHIFT_NONE) begin
			p_out = p_in;
		end else if (mode == SHIFT_LEFT_ONE) begin
			p_out = p_in << SHIFT_BY_ONE;
		end else if (mode == SHIFT_LEFT_FOUR) begin
			p_out = p_in << SHIFT_BY_FOUR;
		end else begin
			// Right shift keeps the sign so scaled-down products stay correct.
			p_out = PW'($signed(p_in) >>> SHIFT_BY_SIX);
		end
	end

endmodule

// ===== dmd_decoder.sv
`timescale 1ns/100ps

module dmd_decoder (
	input  wire logic                        mclk,
	input  wire logic                        resetn,
	input  wire logic                        instr_valid,
	input  wire logic [dmd_pkg::DMD_W-1:0]   instr_word,
	output logic                             instr_ready,
	output dmd_pkg::dmd_mem_req_s            mem_req,
	input  wire logic                        mem_ack,
	input  wire logic [dmd_pkg::DMD_W-1:0]   mem_rdata,
	output logic      [dmd_pkg::DMD_PW-1:0]  acc,
	output logic      [dmd_pkg::DMD_PW-1:0]  product,
	output logic      [dmd_pkg::DMD_W-1:0]   mcand,
	output logic      [7:0][15:0]            index_reg,
	output logic      [dmd_pkg::DMD_PTR_W-1:0] index_ptr,
	output logic      [dmd_pkg::DMD_PAGE_W-1:0] page_ptr,
	output logic      [1:0]                  product_shift_field,
	output logic                             test_flag
);
	import dmd_pkg::*;

	// ==========================================================
	// State, helpers and datapath leaves
	// ==========================================================
	dmd_core_s         s_r;
	dmd_core_s         s_nxt;
	logic [DMD_W-1:0]  mult_a;
	logic [DMD_W-1:0]  mult_b;
	logic              mult_uns;
	logic [DMD_PW-1:0] mult_p;
	logic [DMD_PW-1:0] pshift;
	logic [DMD_W-1:0]  cur_idx;
	logic [DMD_W-1:0]  opnd_addr;
	logic [DMD_W-1:0]  imm13;
	dmd_op_e           dec_op;

	dmd_mult #(
		.W (DMD_W)
	) u_mult (
		.a           (mult_a),
		.b           (mult_b),
		.is_unsigned (mult_uns),
		.p           (mult_p)
	);

	dmd_pshift #(
		.PW (DMD_PW)
	) u_pshift (
		.p_in  (s_r.product),
		.mode  (s_r.shift_field),
		.p_out (pshift)
	);

	// ==========================================================
	// Upper-byte opcode table
	// ==========================================================
	function automatic dmd_op_e dmd_mem_op(input logic [7:0] opc);
		dmd_op_e r;
		r = OP_NONE;
		case (opc)
			OPC_LOAD_MULTIPLICAND:    r = OP_LOAD_MULTIPLICAND;
			OPC_LOAD_MULT_ACCUMULATE: r = OP_LOAD_MULT_ACC;
			OPC_LOAD_MULT_MOVE:       r = OP_LOAD_MULT_MOVE;
			OPC_LOAD_MULT_STORE_PROD: r = OP_LOAD_MULT_STORE;
			OPC_LOAD_MULT_SUBTRACT:   r = OP_LOAD_MULT_SUB;
			OPC_MULTIPLY:             r = OP_MULTIPLY;
			OPC_MULTIPLY_ACC_PREV:    r = OP_MULTIPLY_ACC_PREV;
			OPC_MULTIPLY_SUB_PREV:    r = OP_MULTIPLY_SUB_PREV;
			OPC_MULTIPLY_UNSIGNED:    r = OP_MULTIPLY_UNSIGNED;
			OPC_MULT_ACCUMULATE:      r = OP_MULT_ACCUMULATE;
			OPC_MULT_ACCUMULATE_MOVE: r = OP_MULT_ACC_MOVE;
			OPC_SQUARE_ACCUMULATE:    r = OP_SQUARE_ACC;
			OPC_SQUARE_SUBTRACT:      r = OP_SQUARE_SUB;
			OPC_LOAD_PRODUCT_HIGH:    r = OP_LOAD_PRODUCT_HIGH;
			OPC_STORE_PRODUCT_HIGH:   r = OP_STORE_PRODUCT_HIGH;
			OPC_STORE_PRODUCT_LOW:    r = OP_STORE_PRODUCT_LOW;
			OPC_LOAD_PAGE_POINTER:    r = OP_LOAD_PAGE_POINTER;
			default:                  r = OP_NONE;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Operand selection
	// ==========================================================
	always_comb begin
		cur_idx = s_r.index_reg[s_r.index_ptr];
		if (instr_word[DMD_MODE_BIT]) begin
			opnd_addr = cur_idx;
		end else begin
			opnd_addr = {s_r.page_ptr, instr_word[DMD_OFS_W-1:0]};
		end
		imm13 = {{(DMD_W-DMD_IMM13_W){instr_word[DMD_IMM13_W-1]}},
		         instr_word[DMD_IMM13_W-1:0]};
		dec_op = dmd_mem_op(instr_word[DMD_W-1:DMD_OPC_LSB]);
	end

	// The single multiplier is shared; its operands depend on where the sequencer stands.
	always_comb begin
		mult_a = s_r.mcand;
		mult_b = mem_rdata;
		mult_uns = 1'b0;
		if (s_r.st == ST_FETCH) begin
			mult_b = imm13;
		end else if (s_r.op == OP_MULT_ACCUMULATE || s_r.op == OP_MULT_ACC_MOVE) begin
			mult_a = mem_rdata;
			mult_b = s_r.pword;
		end else if (s_r.op == OP_SQUARE_ACC || s_r.op == OP_SQUARE_SUB) begin
			mult_a = mem_rdata;
		end else if (s_r.op == OP_MULTIPLY_UNSIGNED) begin
			mult_uns = 1'b1;
		end
	end

	// ==========================================================
	// Sequencer and execution
	// ==========================================================
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			ST_FETCH: begin
				if (instr_valid && s_r.ready) begin
					if (instr_word == WORD_ADD_PRODUCT_TO_ACC) begin
						s_nxt.acc = s_r.acc + pshift;
					end else if (instr_word == WORD_PRODUCT_TO_ACC) begin
						s_nxt.acc = pshift;
					end else if (instr_word == WORD_SUB_PRODUCT_FROM) begin
						s_nxt.acc = s_r.acc - pshift;
					end else if (instr_word[15:2] == PAT_SET_PRODUCT_SHIFT) begin
						s_nxt.shift_field = instr_word[1:0];
					end else if (instr_word[15:2] == PAT_COMPARE_INDEX_REGS) begin
						if (instr_word[1:0] == CMP_EQUAL) begin
							s_nxt.test_flag = (cur_idx == s_r.index_reg[0]);
						end else if (instr_word[1:0] == CMP_LESS) begin
							s_nxt.test_flag = (cur_idx < s_r.index_reg[0]);
						end else if (instr_word[1:0] == CMP_GREATER) begin
							s_nxt.test_flag = (cur_idx > s_r.index_reg[0]);
						end else begin
							s_nxt.test_flag = (cur_idx != s_r.index_reg[0]);
						end
					end else if (instr_word[15:3] == PAT_LOAD_INDEX_POINTER) begin
						s_nxt.index_ptr = instr_word[DMD_PTR_W-1:0];
					end else if (instr_word[15:13] == PAT_MULTIPLY_IMMEDIATE) begin
						s_nxt.product = mult_p;
					end else if (instr_word[15:11] == PAT_LOAD_INDEX_SHORT) begin
						s_nxt.index_reg[instr_word[10:8]] =
							{{(DMD_W-DMD_IMM8_W){1'b0}}, instr_word[DMD_IMM8_W-1:0]};
					end else if (instr_word[15:11] == PAT_LOAD_INDEX_LONG &&
					             instr_word[DMD_IMM8_W-1:0] == LONG_LOW_BYTE) begin
						s_nxt.op = OP_LOAD_INDEX_LONG;
						s_nxt.sel = instr_word[10:8];
						s_nxt.st = ST_WORD2;
					end else if (instr_word[15:9] == PAT_LOAD_PAGE_IMMEDIATE) begin
						s_nxt.page_ptr = instr_word[DMD_PAGE_W-1:0];
					end else if (instr_word[15:8] == OPC_ADD_INDEX_SHORT) begin
						s_nxt.index_reg[s_r.index_ptr] =
							cur_idx + {{(DMD_W-DMD_IMM8_W){1'b0}}, instr_word[DMD_IMM8_W-1:0]};
					end else if (instr_word[15:11] == PAT_LOAD_INDEX_REG) begin
						s_nxt.op = OP_LOAD_INDEX_REG;
						s_nxt.sel = instr_word[10:8];
						s_nxt.addr = opnd_addr;
						s_nxt.mem.rd = 1'b1;
						s_nxt.mem.prog = 1'b0;
						s_nxt.mem.addr = opnd_addr;
						s_nxt.st = ST_DREAD;
					end else if (dec_op == OP_MULT_ACCUMULATE || dec_op == OP_MULT_ACC_MOVE) begin
						s_nxt.op = dec_op;
						s_nxt.addr = opnd_addr;
						s_nxt.st = ST_WORD2;
					end else if (dec_op == OP_STORE_PRODUCT_HIGH) begin
						s_nxt.op = dec_op;
						s_nxt.mem.wr = 1'b1;
						s_nxt.mem.prog = 1'b0;
						s_nxt.mem.addr = opnd_addr;
						s_nxt.mem.wdata = pshift[DMD_PW-1:DMD_HALF_LSB];
						s_nxt.st = ST_WRITE;
					end else if (dec_op == OP_STORE_PRODUCT_LOW) begin
						s_nxt.op = dec_op;
						s_nxt.mem.wr = 1'b1;
						s_nxt.mem.prog = 1'b0;
						s_nxt.mem.addr = opnd_addr;
						s_nxt.mem.wdata = pshift[DMD_HALF_LSB-1:0];
						s_nxt.st = ST_WRITE;
					end else if (dec_op != OP_NONE) begin
						s_nxt.op = dec_op;
						s_nxt.addr = opnd_addr;
						s_nxt.mem.rd = 1'b1;
						s_nxt.mem.prog = 1'b0;
						s_nxt.mem.addr = opnd_addr;
						s_nxt.st = ST_DREAD;
					end
				end
			end
			ST_WORD2: begin
				if (instr_valid && s_r.ready) begin
					if (s_r.op == OP_LOAD_INDEX_LONG) begin
						s_nxt.index_reg[s_r.sel] = instr_word;
						s_nxt.op = OP_NONE;
						s_nxt.st = ST_FETCH;
					end else begin
						s_nxt.mem.rd = 1'b1;
						s_nxt.mem.prog = 1'b1;
						s_nxt.mem.addr = instr_word;
						s_nxt.st = ST_PREAD;
					end
				end
			end
			ST_PREAD: begin
				if (mem_ack) begin
					s_nxt.pword = mem_rdata;
					s_nxt.mem.prog = 1'b0;
					s_nxt.mem.addr = s_r.addr;
					s_nxt.st = ST_DREAD;
				end
			end
			ST_DREAD: begin
				if (mem_ack) begin
					s_nxt.mem.rd = 1'b0;
					s_nxt.st = ST_FETCH;
					case (s_r.op)
						OP_LOAD_MULTIPLICAND: begin
							s_nxt.mcand = mem_rdata;
						end
						OP_LOAD_MULT_ACC: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = s_r.acc + pshift;
						end
						OP_LOAD_MULT_MOVE: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = s_r.acc + pshift;
						end
						OP_LOAD_MULT_STORE: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = pshift;
						end
						OP_LOAD_MULT_SUB: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = s_r.acc - pshift;
						end
						OP_MULTIPLY: begin
							s_nxt.product = mult_p;
						end
						OP_MULTIPLY_ACC_PREV: begin
							s_nxt.acc = s_r.acc + pshift;
							s_nxt.product = mult_p;
						end
						OP_MULTIPLY_SUB_PREV: begin
							s_nxt.acc = s_r.acc - pshift;
							s_nxt.product = mult_p;
						end
						OP_MULTIPLY_UNSIGNED: begin
							s_nxt.product = mult_p;
						end
						OP_MULT_ACCUMULATE, OP_MULT_ACC_MOVE: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = s_r.acc + pshift;
							s_nxt.product = mult_p;
						end
						OP_SQUARE_ACC: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = s_r.acc + pshift;
							s_nxt.product = mult_p;
						end
						OP_SQUARE_SUB: begin
							s_nxt.mcand = mem_rdata;
							s_nxt.acc = s_r.acc - pshift;
							s_nxt.product = mult_p;
						end
						OP_LOAD_PRODUCT_HIGH: begin
							s_nxt.product[DMD_PW-1:DMD_HALF_LSB] = mem_rdata;
						end
						OP_LOAD_INDEX_REG: begin
							s_nxt.index_reg[s_r.sel] = mem_rdata;
						end
						OP_LOAD_PAGE_POINTER: begin
							s_nxt.page_ptr = mem_rdata[DMD_PAGE_W-1:0];
						end
						default: begin
							s_nxt.op = OP_NONE;
						end
					endcase
					if (s_r.op == OP_LOAD_MULT_MOVE || s_r.op == OP_MULT_ACC_MOVE) begin
						s_nxt.mem.wr = 1'b1;
						s_nxt.mem.addr = s_r.addr + MOVE_STEP;
						s_nxt.mem.wdata = mem_rdata;
						s_nxt.st = ST_WRITE;
					end
				end
			end
			ST_WRITE: begin
				if (mem_ack) begin
					s_nxt.mem.wr = 1'b0;
					s_nxt.op = OP_NONE;
					s_nxt.st = ST_FETCH;
				end
			end
			default: begin
				s_nxt.st = ST_FETCH;
			end
		endcase
		s_nxt.ready = (s_nxt.st == ST_FETCH) || (s_nxt.st == ST_WORD2);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign instr_ready         = s_r.ready;
	assign mem_req             = s_r.mem;
	assign acc                 = s_r.acc;
	assign product             = s_r.product;
	assign mcand               = s_r.mcand;
	assign index_reg           = s_r.index_reg;
	assign index_ptr           = s_r.index_ptr;
	assign page_ptr            = s_r.page_ptr;
	assign product_shift_field = s_r.shift_field;
	assign test_flag           = s_r.test_flag;

endmodule

// ===== dmd_decoder_sva.sv
`timescale 1ns/100ps
module dmd_decoder_sva (
	input wire logic			mclk,
	input wire logic			resetn,
	input wire logic			instr_valid,
	input wire logic [15:0]			instr_word,
	input wire logic			instr_ready,
	input wire dmd_pkg::dmd_mem_req_s	mem_req,
	input wire logic			mem_ack,
	input wire logic [15:0]			mem_rdata,
	input wire logic [31:0]			acc,
	input wire logic [31:0]			product,
	input wire logic [15:0]			mcand,
	input wire logic [7:0][15:0]		index_reg,
	input wire logic [2:0]			index_ptr,
	input wire logic [8:0]			page_ptr,
	input wire logic [1:0]			product_shift_field,
	input wire logic			test_flag
);
	import dmd_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// A take right after a two-word opener is its second word, not a new instruction.
	logic pend_r;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pend_r <= 1'b0;
		end else if (instr_valid && instr_ready) begin
			pend_r <= !pend_r && (instr_word[15:9] == 7'h2e ||
				(instr_word[15:11] == 5'h1a && instr_word[7:0] == 8'h00));
		end
	end
	sequence s_take;
		instr_valid && instr_ready && !pend_r;
	endsequence
	sequence s_next;
		instr_valid && instr_ready && pend_r;
	endsequence
	sequence s_plain(logic [15:0] w);
		s_take ##0 (instr_word == w && product_shift_field == 2'h0);
	endsequence
	a_mem_start: assert property (s_take ##0 instr_word[15:7] == 9'h079 |=> mem_req.rd && !mem_req.prog && !instr_ready && mem_req.addr == index_reg[index_ptr]) else $error("memory read not started");
	a_pac_load: assert property (s_plain(16'hce14) |=> acc == $past(product)) else $error("acc not loaded from product");
	a_add_product_to_acc_add: assert property (s_plain(16'hce15) |=> acc == $past(acc) + $past(product) && $stable(product)) else $error("product add wrong");
	a_sub_product_from_acc_sub: assert property (s_plain(16'hce16) |=> acc == $past(acc) - $past(product)) else $error("product subtract wrong");
	a_shift_set: assert property (s_take ##0 instr_word[15:2] == 14'h3382 |=> product_shift_field == $past(instr_word[1:0])) else $error("shift mode wrong");
	a_short_load: assert property (s_take ##0 instr_word[15:11] == 5'h18 |=> index_reg[$past(instr_word[10:8])][7:0] == $past(instr_word[7:0])) else $error("short load wrong");
	a_pointer_load: assert property (s_take ##0 instr_word[15:3] == 13'h0ab1 |=> index_ptr == $past(instr_word[2:0])) else $error("pointer load wrong");
	a_page_imm: assert property (s_take ##0 instr_word[15:9] == 7'h64 |=> page_ptr == $past(instr_word[8:0])) else $error("page load wrong");
	a_mac_fetch: assert property (s_take ##0 instr_word[15:9] == 7'h2e ##1 s_next |=> mem_req.rd && mem_req.prog && mem_req.addr == $past(instr_word)) else $error("program operand read wrong");
	a_long_wait: assert property (s_take ##0 instr_word[15:11] == 5'h1a |=> instr_ready && !mem_req.rd && !mem_req.wr) else $error("second word not awaited");
	a_long_load: assert property (s_take ##0 instr_word[15:11] == 5'h1a ##1 s_next |=> index_reg[$past(instr_word[10:8], 2)] == $past(instr_word)) else $error("long load wrong");
endmodule

bind dmd_decoder dmd_decoder_sva chk_u (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
	.instr_word(instr_word), .instr_ready(instr_ready), .mem_req(mem_req), .mem_ack(mem_ack),
	.mem_rdata(mem_rdata), .acc(acc), .product(product), .mcand(mcand), .index_reg(index_reg),
	.index_ptr(index_ptr), .page_ptr(page_ptr), .product_shift_field(product_shift_field),
	.test_flag(test_flag));

// ===== dmd_mem_model.sv
`timescale 1ns/100ps
module dmd_mem_model (
	input wire logic			mclk,
	input wire logic			resetn,
	input wire dmd_pkg::dmd_mem_req_s	mem_req,
	output logic				mem_ack,
	output logic [15:0]			mem_rdata
);
	import dmd_pkg::*;
	logic [1:0]	cnt_r;
	logic [1:0]	dly_r;
	function automatic logic [15:0] val(input logic [15:0] a);
		return {a[6:0], a[15:7]} ^ 16'hb5c3;
	endfunction
	// Latency cycles 0 to 3 so both prompt and slow answers occur.
	// one-cycle acknowledge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			cnt_r <= 2'h0;
			dly_r <= 2'h0;
		end else if ((mem_req.rd || mem_req.wr) && !mem_ack && cnt_r == dly_r) begin
			mem_ack <= 1'b1;
			mem_rdata <= val(mem_req.addr);
			cnt_r <= 2'h0;
			dly_r <= dly_r + 2'h1;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if ((mem_req.rd || mem_req.wr) && !mem_ack) begin
				cnt_r <= cnt_r + 2'h1;
			end
		end
	end
endmodule

// ===== dmd_decoder_bench.sv
`timescale 1ns/100ps
module dmd_decoder_bench;
	import dmd_pkg::*;
	logic		mclk, resetn, instr_valid, instr_ready, mem_ack, test_flag, st;
	logic [15:0]	instr_word, mem_rdata, mcand, sm, wa, wd;
	logic [31:0]	acc, product, sa, sp, lf;
	logic [7:0][15:0] index_reg, sx;
	logic [2:0]	index_ptr, sr;
	logic [8:0]	page_ptr, sg;
	logic [1:0]	product_shift_field, ss;
	dmd_mem_req_s	mem_req;
	int		err_total, check_count, i;
	int		wn = 0;
	logic [15:0] ops [29] = '{16'hc000, 16'h5588, 16'hc800, 16'hd000, 16'h7e00, 16'hce50,
		16'hce08, 16'hce14, 16'hce15, 16'hce16, 16'h3c00, 16'h3d00, 16'h3e00, 16'h5b00,
		16'h3800, 16'h3a00, 16'h3b00, 16'hcf00, 16'ha000, 16'h3900, 16'h5a00, 16'h5300,
		16'h4f00, 16'h5d00, 16'h3000, 16'h3f00, 16'h5c00, 16'h7d00, 16'h7c00};
	logic [15:0] msk [29] = '{16'h07ff, 16'h0007, 16'h01ff, 16'h0700, 16'h00ff, 16'h0003,
		16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff,
		16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h1fff, 16'h00ff, 16'h00ff, 16'h00ff,
		16'h00ff, 16'h00ff, 16'h07ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
	dmd_decoder dut_u (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .mem_req(mem_req),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .acc(acc), .product(product),
		.mcand(mcand), .index_reg(index_reg), .index_ptr(index_ptr), .page_ptr(page_ptr),
		.product_shift_field(product_shift_field), .test_flag(test_flag));
	dmd_mem_model mdl_u (.mclk(mclk), .resetn(resetn), .mem_req(mem_req), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	// Every acknowledged write is recorded so stores and data moves can be checked.
	always @(posedge mclk) begin
		if (mem_req.wr && mem_ack) begin
			wa <= mem_req.addr;
			wd <= mem_req.wdata;
			wn <= wn + 1;
		end
	end
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	function automatic logic [15:0] nxt();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[15:0];
	endfunction
	function automatic logic [31:0] shp(input logic [31:0] p, input logic [1:0] m);
		case (m)
			2'h1: return p << 1;
			2'h2: return p << 4;
			2'h3: return {{6{p[31]}}, p[31:6]};
			default: return p;
		endcase
	endfunction
	function automatic logic [31:0] mul(input logic [15:0] a, b, input logic u);
		if (u) return {16'h0000, a} * {16'h0000, b};
		return {{16{a[15]}}, a} * {{16{b[15]}}, b};
	endfunction
	function automatic logic cmp(input logic [1:0] c, input logic [15:0] x, z);
		case (c)
			2'h0: return x == z;
			2'h1: return x < z;
			2'h2: return x > z;
			default: return x != z;
		endcase
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic settle();
		int n;
		n = 0;
		@(negedge mclk);
		while (instr_ready !== 1'b1) begin
			n++;
			if (n > 100) begin
				err_total++;
				conclude();
			end
			@(negedge mclk);
		end
	endtask
	// Valid stays up between the words of a pair so the second word follows at once.
	task automatic issue(input logic [15:0] w0, w1, input int k);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word <= w0;
		settle();
		@(posedge mclk);
		if (k == 2) begin
			instr_word <= w1;
			settle();
			@(posedge mclk);
		end
		instr_valid <= 1'b0;
		settle();
	endtask
	task automatic verify();
		chk("acc", sa, acc);
		chk("product", sp, product);
		chk("mcand", sm, mcand);
		chk("index_reg", sx, index_reg);
		chk("index_ptr", sr, index_ptr);
		chk("page_ptr", sg, page_ptr);
		chk("shift", ss, product_shift_field);
		chk("test_flag", st, test_flag);
		chk("mem_idle", 2'h0, {mem_req.rd, mem_req.wr});
	endtask
	task automatic run(input logic [15:0] w);
		logic [15:0] w1, d, pd, ad, ea, ed;
		logic [31:0] op;
		int ew, n0;
		w1 = nxt();
		ad = w[7] ? sx[sr] : {sg, w[6:0]};
		d = mdl_u.val(ad);
		pd = mdl_u.val(w1);
		op = shp(sp, ss);
		ew = 0;
		ea = 16'h0000;
		ed = 16'h0000;
		n0 = wn;
		issue(w, w1, (w[15:9] == 7'h2e || w[15:11] == 5'h1a) ? 2 : 1);
		casez (w)
			16'hce14: sa = op;
			16'hce15: sa += op;
			16'hce16: sa -= op;
			16'b1100_1110_0000_10??: ss = w[1:0];
			16'b1100_1110_0101_00??: st = cmp(w[1:0], sx[sr], sx[0]);
			16'b0101_0101_1000_1???: sr = w[2:0];
			16'b1100_100?_????_????: sg = w[8:0];
			16'b1100_0???_????_????: sx[w[10:8]] = {8'h00, w[7:0]};
			16'b1101_0???0000_0000: sx[w[10:8]] = w1;
			16'h7e??: sx[sr] += {8'h00, w[7:0]};
			16'b101?_????_????_????: sp = mul(sm, {{3{w[12]}}, w[12:0]}, 1'b0);
			16'h3c??: sm = d;
			16'h3d??, 16'h3f??: begin sm = d; sa += op; end
			16'h3e??: begin sm = d; sa = op; end
			16'h5b??: begin sm = d; sa -= op; end
			16'h38??: sp = mul(sm, d, 1'b0);
			16'h3a??: begin sp = mul(sm, d, 1'b0); sa += op; end
			16'h3b??: begin sp = mul(sm, d, 1'b0); sa -= op; end
			16'hcf??: sp = mul(sm, d, 1'b1);
			16'h39??: begin sm = d; sp = mul(d, d, 1'b0); sa += op; end
			16'h5a??: begin sm = d; sp = mul(d, d, 1'b0); sa -= op; end
			16'h53??: sp[31:16] = d;
			16'h4f??: sg = d[8:0];
			16'h5d??, 16'h5c??: begin sm = d; sp = mul(d, pd, 1'b0); sa += op; end
			16'h7d??: begin ew = 1; ea = ad; ed = op[31:16]; end
			16'h7c??: begin ew = 1; ea = ad; ed = op[15:0]; end
			16'b0011_0???_????_????: sx[w[10:8]] = d;
			default: ;
		endcase
		if (w[15:8] == 8'h3f || w[15:8] == 8'h5c) begin
			ew = 1;
			ea = ad + 16'h0001;
			ed = d;
		end
		verify();
		chk("writes", ew, wn - n0);
		if (ew != 0) begin
			chk("write_addr", ea, wa);
			chk("write_data", ed, wd);
		end
	endtask
	initial begin
		resetn = 1'b0;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		lf = 32'h6deb_0e1c;
		{sa, sp, sm, sx, sr, sg, ss, st} = '0;
		err_total = 0;
		check_count = 0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		verify();
		// Equal and unequal compares, then selecting the arithmetic right shift product mode.
		run(16'hc005);
		run(16'h5589);
		run(16'hc105);
		run(16'hce50);
		run(16'hce53);
		run(16'hce0b);
		repeat (600) begin
			i = nxt() % 29;
			run(ops[i] | (nxt() & msk[i]));
		end
		conclude();
	end
endmodule
